// ### design/ana_regs.v
// negotiation advertisement, partner ability and expansion registers
// assumes a management frame decoder gives index, write strobe, read strobe
// and that the negotiation engine shares sys_clk; strap and engine inputs
// are same-clock signals
`timescale 1ns/10ps
`include "ana_regs_map.vh"
module ana_regs (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [4:0]  regIdx,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  input  wire        strap100Fd,
  input  wire        strap10Fd,
  input  wire        strap10,
  input  wire        codeWordValid,
  input  wire [15:0] codeWord,
  input  wire        parDetFault,
  input  wire        pageReceived,
  input  wire        partnerAnAble,
  input  wire        negDone,
  output reg         negRestart,
  output reg  [1:0]  pauseResolved,
  output reg  [15:0] advWord
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg  [15:0] advReg;
  reg  [15:0] advNext;
  reg  [15:0] lpaReg;
  reg  [15:0] lpaNext;
  reg         ackReg;
  reg         lpanReg;
  reg         doneReg;
  reg         strapLoadReg;
  reg  [15:0] rdNext;
  reg  [15:0] strapVal;
  reg  [1:0]  pauseNext;
  wire [1:0]  flagEvent;
  wire [1:0]  flagReg;
  wire        expRead;
  wire        advWr;
  wire        ctrlWr;
  wire        pdfReg;
  wire        prReg;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  assign expRead = regRead && (regIdx == `ANA_IDX_EXP);
  assign advWr   = regWrite && (regIdx == `ANA_IDX_ADV);
  assign ctrlWr  = regWrite && (regIdx == `ANA_IDX_CTRL);

  // ----------------------------------------
  // strap-derived advertisement default
  // ----------------------------------------
  // straps sampled one edge after reset release, not under reset
  always @* begin
    strapVal                = 16'h0000;
    strapVal[4:0]           = `ANA_SEL_IEEE;
    strapVal[`ANA_B_10]     = strap10;
    strapVal[`ANA_B_10FD]   = strap10Fd;
    strapVal[`ANA_B_100]    = 1'b1;
    strapVal[`ANA_B_100FD]  = strap100Fd;
    strapVal[`ANA_B_PAUSE_HI:`ANA_B_PAUSE_LO] = `ANA_PAUSE_RST;
    strapVal[`ANA_B_RF]     = 1'b0;
  end

  always @* begin
    advNext = advReg;
    if (strapLoadReg) begin
      advNext = strapVal;
    end else if (advWr) begin
      advNext = regWdata & `ANA_ADV_WMASK;
    end
  end

  // ----------------------------------------
  // advertisement register
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      strapLoadReg <= 1'b1;
      advReg       <= `ANA_ADV_RST;
    end else begin
      strapLoadReg <= 1'b0;
      advReg       <= advNext;
    end
  end

  // ----------------------------------------
  // partner ability and expansion status
  // ----------------------------------------
  // next page, acknowledge and T4 forced low; reserved bit 12 and pause high bit 11 dropped
  always @* begin
    lpaNext            = codeWord & `ANA_LPA_MASK;
    lpaNext[`ANA_B_NP]  = 1'b0;
    lpaNext[`ANA_B_ACK] = 1'b0;
    lpaNext[`ANA_B_T4]  = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      lpaReg  <= {11'h000, `ANA_SEL_IEEE};
      ackReg  <= 1'b0;
      lpanReg <= 1'b0;
      doneReg <= 1'b0;
    end else begin
      if (codeWordValid) begin
        lpaReg <= lpaNext;
        ackReg <= 1'b1;
      end
      lpanReg <= partnerAnAble;
      if (negRestart) begin
        doneReg <= 1'b0;
        ackReg  <= 1'b0;
      end else if (negDone) begin
        doneReg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // latching-high expansion flags
  // ----------------------------------------
  assign flagEvent = {parDetFault, pageReceived};
  genvar fi;
  generate
    for (fi = 0; fi < 2; fi = fi + 1) begin : gen_latch
      reg latchReg;
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          latchReg <= 1'b0;
        end else begin
          // set beats the read-clear so a coincident event survives
          latchReg <= flagEvent[fi] | (latchReg & ~expRead);
        end
      end
      assign flagReg[fi] = latchReg;
    end
  endgenerate
  assign pdfReg = flagReg[1];
  assign prReg  = flagReg[0];

  // ----------------------------------------
  // restart pulse and pause resolution
  // ----------------------------------------
  always @* begin
    case ({advReg[`ANA_B_PAUSE_HI], advReg[`ANA_B_PAUSE_LO]})
      2'h1, 2'h3: begin
        // both local bits set still resolves to one setting only
        if (lpaReg[`ANA_B_PAUSE_LO]) begin
          pauseNext = 2'h1;
        end else if (advReg[`ANA_B_PAUSE_HI]) begin
          pauseNext = 2'h2;
        end else begin
          pauseNext = 2'h0;
        end
      end
      2'h2: pauseNext = 2'h2;
      default: pauseNext = 2'h0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      negRestart <= 1'b0;
    end else begin
      // write of one gives a one-cycle pulse; the bit reads back zero
      negRestart <= ctrlWr && regWdata[`ANA_CTRL_RESTART];
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pauseResolved <= 2'h0;
      advWord       <= 16'h0000;
    end else begin
      advWord <= advNext;
      if (doneReg) begin
        pauseResolved <= pauseNext;
      end else begin
        pauseResolved <= 2'h0;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rdNext = 16'h0000;
    case (regIdx)
      `ANA_IDX_CTRL: rdNext = 16'h0000;
      `ANA_IDX_STAT: rdNext[`ANA_STAT_DONE] = doneReg;
      `ANA_IDX_ADV:  rdNext = advReg;
      `ANA_IDX_LPA: begin
        rdNext = lpaReg;
        rdNext[`ANA_B_ACK] = ackReg;
      end
      `ANA_IDX_EXP: begin
        rdNext[`ANA_EXP_PDF]  = pdfReg;
        rdNext[`ANA_EXP_LPNP] = 1'b0;
        rdNext[`ANA_EXP_NP]   = 1'b0;
        rdNext[`ANA_EXP_PR]   = prReg;
        rdNext[`ANA_EXP_LPAN] = lpanReg;
      end
      default: rdNext = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      regRdata <= rdNext;
    end
  end
endmodule

// ### inc/ana_regs_map.vh
// constants for the negotiation ability register set
// assumes 16-bit management registers addressed by 5-bit index
`ifndef ANA_REGS_MAP_VH
`define ANA_REGS_MAP_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define ANA_IDX_CTRL    5'h00
`define ANA_IDX_STAT    5'h01
`define ANA_IDX_ADV     5'h04
`define ANA_IDX_LPA     5'h05
`define ANA_IDX_EXP     5'h06
// ----------------------------------------
// field positions
// ----------------------------------------
`define ANA_CTRL_RESTART 9
`define ANA_STAT_DONE    5
`define ANA_B_NP         15
`define ANA_B_ACK        14
`define ANA_B_RF         13
`define ANA_B_PAUSE_HI   11
`define ANA_B_PAUSE_LO   10
`define ANA_B_T4         9
`define ANA_B_100FD      8
`define ANA_B_100        7
`define ANA_B_10FD       6
`define ANA_B_10         5
`define ANA_EXP_PDF      4
`define ANA_EXP_LPNP     3
`define ANA_EXP_NP       2
`define ANA_EXP_PR       1
`define ANA_EXP_LPAN     0
// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define ANA_ADV_WMASK   16'h2DFF
`define ANA_LPA_MASK    16'hE7FF
`define ANA_SEL_IEEE    5'h01
`define ANA_PAUSE_RST   2'h0
`define ANA_ADV_RST     16'h01E1
`endif

// ### verif/ana_regs_checker.sv
// checker: port relations of the negotiation register set
// assumes binding into ana_regs, one clock domain
`timescale 1ns/10ps
module ana_regs_checker (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        regWrite,
  input logic        regRead,
  input logic        codeWordValid,
  input logic        parDetFault,
  input logic        negRestart,
  input logic [4:0]  regIdx,
  input logic [15:0] regWdata,
  input logic [15:0] regRdata,
  input logic [15:0] codeWord,
  input logic [15:0] advWord,
  input logic [1:0]  pauseResolved
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire rdL = regRead && regIdx == 5'h05;
  wire rdE = regRead && regIdx == 5'h06;
  AST_RESTART: assert property (regWrite && regIdx == 5'h00 && regWdata[9] |=> negRestart)
    else $error("restart pulse missing");
  AST_RESTART_SRC: assert property (negRestart |-> $past(regWrite && regIdx == 5'h00 && regWdata[9]))
    else $error("restart pulse without cause");
  AST_ADV_WR: assert property (regWrite && regIdx == 5'h04 && $past(rst_n) |=> advWord == ($past(regWdata) & 16'h2DFF))
    else $error("advertisement write wrong");
  AST_PAUSE: assert property (pauseResolved != 2'h3)
    else $error("two pause settings resolved");
  AST_LPA_RSV: assert property (rdL |=> regRdata[15] == 1'b0 && regRdata[12:11] == 2'h0 && !regRdata[9])
    else $error("partner fixed bits not zero");
  AST_LPA_WORD: assert property (codeWordValid ##1 rdL |=> regRdata == ($past(codeWord, 2) & 16'h65FF | 16'h4000))
    else $error("partner word wrong");
  AST_EXP_RSV: assert property (rdE |=> regRdata[15:5] == 11'h000 && !regRdata[2])
    else $error("expansion fixed bits not zero");
  AST_PDF: assert property (parDetFault ##1 rdE |=> regRdata[4])
    else $error("fault flag not latched");
endmodule
bind ana_regs ana_regs_checker ana_regs_checker_inst (.*);

// ### verif/ana_engine_model.sv
// stand-in for the negotiation engine: partner words and events
// assumes tasks are called just after a sys_clk edge
`timescale 1ns/10ps
module ana_engine_model (
  input  logic        sys_clk,
  output logic        codeWordValid,
  output logic        parDetFault,
  output logic        pageReceived,
  output logic        negDone,
  output logic        partnerAnAble,
  output logic [15:0] codeWord
);
  initial {codeWordValid, parDetFault, pageReceived, negDone, partnerAnAble, codeWord} = '0;
  // word is stale once valid drops, so inverted rather than held
  task automatic send(input logic [15:0] w);
    @(posedge sys_clk);
    codeWord <= w;
    codeWordValid <= 1'b1;
    @(posedge sys_clk);
    codeWordValid <= 1'b0;
    codeWord <= ~w;
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge sys_clk);
    {partnerAnAble, parDetFault, pageReceived, negDone} <= m;
    @(posedge sys_clk);
    {parDetFault, pageReceived, negDone} <= 3'h0;
  endtask
endmodule

// ### verif/testbench.sv
// bench for the negotiation register set
// assumes ana_regs with checker bound, engine stand-in
`timescale 1ns/10ps
module testbench;
  logic        sys_clk = 0, rst_n = 0, regWrite = 0, regRead = 0;
  logic        strap100Fd = 1, strap10Fd = 0, strap10 = 1;
  logic [4:0]  regIdx = '0;
  logic [15:0] regWdata = '0, regRdata, advWord, codeWord;
  logic        codeWordValid, parDetFault, pageReceived, partnerAnAble, negDone, negRestart;
  logic [1:0]  pauseResolved;
  int          fails = 0, cmp_count = 0;
  initial forever #4 sys_clk = ~sys_clk;
  ana_engine_model ana_engine_model_inst (
    .sys_clk       (sys_clk),
    .codeWordValid (codeWordValid),
    .parDetFault   (parDetFault),
    .pageReceived  (pageReceived),
    .negDone       (negDone),
    .partnerAnAble (partnerAnAble),
    .codeWord      (codeWord)
  );
  ana_regs ana_regs_inst (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .regIdx        (regIdx),
    .regWrite      (regWrite),
    .regRead       (regRead),
    .regWdata      (regWdata),
    .regRdata      (regRdata),
    .strap100Fd    (strap100Fd),
    .strap10Fd     (strap10Fd),
    .strap10       (strap10),
    .codeWordValid (codeWordValid),
    .codeWord      (codeWord),
    .parDetFault   (parDetFault),
    .pageReceived  (pageReceived),
    .partnerAnAble (partnerAnAble),
    .negDone       (negDone),
    .negRestart    (negRestart),
    .pauseResolved (pauseResolved),
    .advWord       (advWord)
  );
  task automatic chk(input string n, input logic [15:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    {regIdx, regWdata, regWrite} <= {i, d, 1'b1};
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    @(posedge sys_clk);
    {regIdx, regRead} <= {i, 1'b1};
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk("regRdata", e, regRdata);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(5'h04, 16'h01A1);
    rd(5'h05, 16'h0001);
    rd(5'h06, 16'h0000);
    wr(5'h04, 16'hFFFF);
    rd(5'h04, 16'h2DFF);
    chk("advWord", 16'h2DFF, advWord);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0001);
    fork
      ana_engine_model_inst.send(16'hFFFF);
      begin
        @(posedge sys_clk);
        rd(5'h05, 16'h65FF);
      end
    join
    fork
      ana_engine_model_inst.ev(4'hC);
      begin
        @(posedge sys_clk);
        rd(5'h06, 16'h0011);
      end
    join
    rd(5'h06, 16'h0001);
    fork
      ana_engine_model_inst.ev(4'hA);
      begin
        @(posedge sys_clk);
        rd(5'h06, 16'h0003);
      end
    join
    rd(5'h06, 16'h0001);
    ana_engine_model_inst.ev(4'h9);
    rd(5'h01, 16'h0020);
    chk("pauseResolved", 16'h0001, {14'h0, pauseResolved});
    wr(5'h00, 16'h0200);
    rd(5'h01, 16'h0000);
    rd(5'h1F, 16'h0000);
    final_report;
  end
endmodule
